// [fifo_port_cfg.svh]
`ifndef FIFO_PORT_CFG_SVH
`define FIFO_PORT_CFG_SVH
// ----------------------------------------
// Buffer sizes
// ----------------------------------------
`define FP_RX_DEPTH       128
`define FP_TX_DEPTH       385
`define FP_PKT_BYTES      64
// ----------------------------------------
// Timing
// ----------------------------------------
`define FP_CLK_NS         100
`define FP_MS_NS          1000000
`define FP_POR_HOLD_NS    2000000
`define FP_TMO_DEF_MS     8'h10
`define FP_TMO_MIN_MS     8'h01
`define FP_GAP_CYCLES     4
`define FP_FLUSH_CYCLES   2
// ----------------------------------------
// Controller registers (byte offsets)
// ----------------------------------------
`define FP_REG_TXDATA     4'h0
`define FP_REG_RXDATA     4'h4
`define FP_REG_STATUS     4'h8
`define FP_REG_CTRL       4'hC
`define FP_ST_RXAVAIL     0
`define FP_ST_TXSPACE     1
`define FP_ST_TXPEND      2
`define FP_ST_RXHAVE      3
`define FP_ST_SUSP        4
`define FP_ST_VARIANT     5
`define FP_ST_RSTGEN      6
`define FP_CT_FLUSH       0
`define FP_CT_DEVRST      1
`define FP_CT_AUTORD      2
`define FP_CTRL_RESET     32'h0000_0000
`define FP_RESP_OKAY      2'h0
`define FP_RESP_SLVERR    2'h2
`endif

// [fifo_port_pkg.sv]
package fifo_port_pkg;
  // ----------------------------------------
  // Controller strobe sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    H_IDLE,
    H_WR_SETUP,
    H_WR_LOW,
    H_WR_HOLD,
    H_RD_LOW,
    H_RD_CAP,
    H_GAP
  } host_state_type;
endpackage : fifo_port_pkg

// [fifo_port_if.sv]
`timescale 1ns/10ps
interface fifo_port_if;
  logic [7:0] dev_data;        // Device drive value
  logic       dev_data_oe;
  logic [7:0] host_data;       // Controller drive value
  logic       host_data_oe;
  logic [7:0] bus_level;       // Resolved bus, pulled high when idle
  logic       rd_n;
  logic       wr_n;
  logic       rx_avail_n;
  logic       tx_full_n;
  logic       flush_wake_in;
  logic       reset_n;         // External reset into the device
  logic       reset_gen_pin;
  logic       reset_gen_pin_oe;
  logic       reset_gen_level; // Resolved, pulled low when released
  logic       suspend_ind;
  logic       variant_strap;

  // Wire resolution; contention favours the device
  assign bus_level       = dev_data_oe ? dev_data : (host_data_oe ? host_data : 8'hFF);
  assign reset_gen_level = reset_gen_pin_oe ? reset_gen_pin : 1'b0;

  modport dev (
    output dev_data, dev_data_oe, rx_avail_n, tx_full_n, reset_gen_pin,
           reset_gen_pin_oe, suspend_ind, variant_strap,
    input  bus_level, rd_n, wr_n, flush_wake_in, reset_n
  );
  modport ctrl (
    output host_data, host_data_oe, rd_n, wr_n, flush_wake_in, reset_n,
    input  bus_level, rx_avail_n, tx_full_n, reset_gen_level, suspend_ind,
           variant_strap
  );
endinterface : fifo_port_if

// [fifo_port_device.sv]
// Function
// - Receive flag low while bytes wait
// - Receive flag high once buffer empty
// - Transmit flag high when full or storing
// - Controller never writes while transmit flag high
// - Write falling edge captures bus byte
// - Held bytes forwarded within transmit timeout
// - Timeout settable 1 to 255 ms
// - Read low drives current byte on bus
// - Read high releases bus, advances byte
// - Send edge in suspend requests wakeup
// - Send edge when active flushes buffer
// - Suspend indicator low configured, high suspended
// - Reset generator released ~2 ms, then driven
// - External reset low releases reset generator
// - External reset held high when unused
// - Variant output low for parallel port
// - Controller keeps draining receive buffer
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"
module fifo_port_device
  import fifo_port_pkg::*;
#(
  parameter int RX_DEPTH   = `FP_RX_DEPTH,
  parameter int TX_DEPTH   = `FP_TX_DEPTH,
  parameter int PKT_BYTES  = `FP_PKT_BYTES,
  parameter int MS_CYCLES  = `FP_MS_NS / `FP_CLK_NS,
  parameter int POR_CYCLES = `FP_POR_HOLD_NS / `FP_CLK_NS,
  parameter bit VARIANT    = 1'b0
) (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  fifo_port_if.dev        port,
  input  wire logic [7:0] usb_rx_data_in,
  input  wire logic       usb_rx_valid_in,
  output logic            usb_rx_ready_out,
  output logic [7:0]      usb_tx_data_out,
  output logic            usb_tx_valid_out,
  input  wire logic       usb_tx_ready_in,
  input  wire logic       usb_configured_in,
  input  wire logic       usb_suspend_in,
  input  wire logic       usb_bus_reset_in,
  input  wire logic [7:0] timeout_ms_in,
  output logic            wake_req_out
);
  localparam int RPW = $clog2(RX_DEPTH);
  localparam int RCW = $clog2(RX_DEPTH + 1);
  localparam int TPW = $clog2(TX_DEPTH);
  localparam int TCW = $clog2(TX_DEPTH + 1);
  localparam int MSW = $clog2(MS_CYCLES);
  localparam int PRW = $clog2(POR_CYCLES + 1);
  localparam logic [RCW-1:0] RX_FULL  = RCW'(RX_DEPTH);
  localparam logic [RPW-1:0] RX_LAST  = RPW'(RX_DEPTH - 1);
  localparam logic [TCW-1:0] TX_FULL  = TCW'(TX_DEPTH);
  localparam logic [TPW-1:0] TX_LAST  = TPW'(TX_DEPTH - 1);
  localparam logic [TCW-1:0] TX_PKT   = TCW'(PKT_BYTES);
  localparam logic [MSW-1:0] MS_LAST  = MSW'(MS_CYCLES - 1);
  localparam logic [PRW-1:0] POR_DONE = PRW'(POR_CYCLES);

  // ----------------------------------------
  // Resets and strobe edges
  // ----------------------------------------
  logic           fifo_rst;
  logic           por_rst;
  logic           rd_prev_r;
  logic           wr_prev_r;
  logic           flush_prev_r;
  logic           rd_rise;
  logic           wr_fall;
  logic           flush_rise;

  // Buffers clear on any reset, including a bus reset
  assign fifo_rst = !resetn_in || !port.reset_n || usb_bus_reset_in;
  // Reset generator ignores the bus reset
  assign por_rst  = !resetn_in || !port.reset_n;

  // Previous strobe levels; read and write idle high, send idle low
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rd_prev_r    <= 1'b1;
      wr_prev_r    <= 1'b1;
      flush_prev_r <= 1'b0;
    end else begin
      rd_prev_r    <= port.rd_n;
      wr_prev_r    <= port.wr_n;
      flush_prev_r <= port.flush_wake_in;
    end
  end

  assign rd_rise    = !rd_prev_r && port.rd_n;
  assign wr_fall    = wr_prev_r && !port.wr_n;
  assign flush_rise = !flush_prev_r && port.flush_wake_in;

  // ----------------------------------------
  // Receive buffer
  // ----------------------------------------
  logic [7:0]     rx_mem [RX_DEPTH];
  logic [RPW-1:0] rx_wr_ptr_r;
  logic [RPW-1:0] rx_rd_ptr_r;
  logic [RCW-1:0] rx_cnt_r;
  logic [7:0]     rd_data_r;
  logic           rx_push;
  logic           rx_pop;

  assign rx_push          = usb_rx_valid_in && (rx_cnt_r != RX_FULL);
  assign usb_rx_ready_out = (rx_cnt_r != RX_FULL);
  assign rx_pop           = rd_rise && (rx_cnt_r != '0);

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk_in) begin
    if (rx_push) begin
      rx_mem[rx_wr_ptr_r] <= usb_rx_data_in;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk_in) begin
    if (fifo_rst) begin
      rx_wr_ptr_r <= '0;
      rx_rd_ptr_r <= '0;
      rx_cnt_r    <= '0;
    end else begin
      if (rx_push) begin
        rx_wr_ptr_r <= (rx_wr_ptr_r == RX_LAST) ? '0 : rx_wr_ptr_r + 1'b1;
      end
      if (rx_pop) begin
        rx_rd_ptr_r <= (rx_rd_ptr_r == RX_LAST) ? '0 : rx_rd_ptr_r + 1'b1;
      end
      if (rx_push && !rx_pop) begin
        rx_cnt_r <= rx_cnt_r + 1'b1;
      end else if (rx_pop && !rx_push) begin
        rx_cnt_r <= rx_cnt_r - 1'b1;
      end
    end
  end

  // Head byte refreshed every cycle so it is ready when read falls
  always_ff @(posedge clk_in) begin
    if (fifo_rst) begin
      rd_data_r <= '0;
    end else begin
      rd_data_r <= rx_mem[rx_rd_ptr_r];
    end
  end

  assign port.dev_data    = rd_data_r;
  assign port.dev_data_oe = !port.rd_n;
  assign port.rx_avail_n  = (rx_cnt_r == '0);

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  logic [7:0]     tx_mem [TX_DEPTH];
  logic [TPW-1:0] tx_wr_ptr_r;
  logic [TPW-1:0] tx_rd_ptr_r;
  logic [TCW-1:0] tx_cnt_r;
  logic           store_busy_r;
  logic           tx_push;
  logic           tx_pop;

  // A strobe against a raised flag is dropped, not stored
  assign tx_push = wr_fall && (tx_cnt_r != TX_FULL) && !store_busy_r;
  assign tx_pop  = usb_tx_valid_out && usb_tx_ready_in;

  always_ff @(posedge clk_in) begin
    if (tx_push) begin
      tx_mem[tx_wr_ptr_r] <= port.bus_level;
    end
  end

  always_ff @(posedge clk_in) begin
    if (fifo_rst) begin
      tx_wr_ptr_r  <= '0;
      tx_rd_ptr_r  <= '0;
      tx_cnt_r     <= '0;
      store_busy_r <= 1'b0;
    end else begin
      store_busy_r <= tx_push;
      if (tx_push) begin
        tx_wr_ptr_r <= (tx_wr_ptr_r == TX_LAST) ? '0 : tx_wr_ptr_r + 1'b1;
      end
      if (tx_pop) begin
        tx_rd_ptr_r <= (tx_rd_ptr_r == TX_LAST) ? '0 : tx_rd_ptr_r + 1'b1;
      end
      if (tx_push && !tx_pop) begin
        tx_cnt_r <= tx_cnt_r + 1'b1;
      end else if (tx_pop && !tx_push) begin
        tx_cnt_r <= tx_cnt_r - 1'b1;
      end
    end
  end

  assign port.tx_full_n = (tx_cnt_r == TX_FULL) || store_busy_r;

  // ----------------------------------------
  // Transmit release: timeout, flush, full packet
  // ----------------------------------------
  logic [MSW-1:0] ms_div_r;
  logic [7:0]     ms_cnt_r;
  logic [7:0]     tmo_eff;
  logic           release_r;
  logic           ms_tick;
  logic           tmo_hit;
  logic           flush_req;

  // Zero would expire on the first millisecond tick, the same as the minimum it is raised to
  assign tmo_eff   = (timeout_ms_in < `FP_TMO_MIN_MS) ? `FP_TMO_MIN_MS : timeout_ms_in;
  assign ms_tick   = (ms_div_r == MS_LAST);
  assign tmo_hit   = ms_tick && (ms_cnt_r + 8'h01 >= tmo_eff);
  assign flush_req = flush_rise && !usb_suspend_in;

  // Millisecond divider, free running
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ms_div_r <= '0;
    end else begin
      ms_div_r <= ms_tick ? '0 : ms_div_r + 1'b1;
    end
  end

  // Age of held data; restarts whenever the buffer empties
  always_ff @(posedge clk_in) begin
    if (fifo_rst || tx_cnt_r == '0 || release_r) begin
      ms_cnt_r <= '0;
    end else if (ms_tick) begin
      ms_cnt_r <= ms_cnt_r + 8'h01;
    end
  end

  // Release stays until drained; a new cause wins over the clear
  always_ff @(posedge clk_in) begin
    if (fifo_rst) begin
      release_r <= 1'b0;
    end else if ((tmo_hit && tx_cnt_r != '0) || flush_req || tx_cnt_r >= TX_PKT) begin
      release_r <= 1'b1;
    end else if (tx_cnt_r == '0 || (tx_cnt_r == TCW'(1) && tx_pop && !tx_push)) begin
      release_r <= 1'b0;
    end
  end

  // Whole buffer goes out on the next IN request once released
  assign usb_tx_valid_out = release_r && (tx_cnt_r != '0);
  assign usb_tx_data_out  = tx_mem[tx_rd_ptr_r];

  // ----------------------------------------
  // Wakeup and suspend indicator
  // ----------------------------------------
  logic           wake_r;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      wake_r <= 1'b0;
    end else begin
      wake_r <= flush_rise && usb_suspend_in;
    end
  end

  assign wake_req_out     = wake_r;
  // High until configured, high again in suspend
  assign port.suspend_ind = !usb_configured_in || usb_suspend_in;

  // ----------------------------------------
  // Reset generator and variant strap
  // ----------------------------------------
  logic [PRW-1:0] por_cnt_r;

  // Counts from release of resetn_in; external reset restarts it
  always_ff @(posedge clk_in) begin
    if (por_rst) begin
      por_cnt_r <= '0;
    end else if (por_cnt_r != POR_DONE) begin
      por_cnt_r <= por_cnt_r + 1'b1;
    end
  end

  assign port.reset_gen_pin    = 1'b1;                        // Clamped to the rail
  assign port.reset_gen_pin_oe = (por_cnt_r == POR_DONE);
  assign port.variant_strap    = VARIANT;
endmodule : fifo_port_device

// [fifo_port_ctrl.sv]
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "fifo_port_cfg.svh"
module fifo_port_ctrl
  import fifo_port_pkg::*;
#(
  parameter int GAP_CYCLES   = `FP_GAP_CYCLES,
  parameter int FLUSH_CYCLES = `FP_FLUSH_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  fifo_port_if.ctrl        port,
  input  wire logic [3:0]  awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  input  wire logic [3:0]  araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in
);
  // ----------------------------------------
  // Flag synchronisers
  // ----------------------------------------
  logic [3:0]     sync1_r;
  logic [3:0]     sync2_r;
  logic           rx_avail;
  logic           tx_space;

  // Flags change with the device's strobes, so two stages
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      sync1_r <= 4'h3;
      sync2_r <= 4'h3;
    end else begin
      sync1_r <= {port.reset_gen_level, port.suspend_ind, port.tx_full_n, port.rx_avail_n};
      sync2_r <= sync1_r;
    end
  end

  assign rx_avail = !sync2_r[0];
  assign tx_space = !sync2_r[1];

  // ----------------------------------------
  // Register address decode
  // ----------------------------------------
  function automatic logic is_reg(input logic [3:0] a, input logic [3:0] off);
    is_reg = (a == off);
  endfunction : is_reg

  // ----------------------------------------
  // AXI4-Lite write channels
  // ----------------------------------------
  logic           aw_hold_r;
  logic           w_hold_r;
  logic [3:0]     aw_addr_r;
  logic [31:0]    w_data_r;
  logic [3:0]     w_strb_r;
  logic           do_write;
  logic           tx_wr;
  logic           tx_take;
  logic           tx_pend_r;
  logic [7:0]     tx_byte_r;
  logic [31:0]    ctrl_r;
  logic           flush_start;

  assign awready_out = !aw_hold_r && !bvalid_out;
  assign wready_out  = !w_hold_r && !bvalid_out;
  assign do_write    = aw_hold_r && w_hold_r && !bvalid_out;
  assign tx_wr       = do_write && is_reg(aw_addr_r, `FP_REG_TXDATA) && w_strb_r[0];
  assign flush_start = do_write && is_reg(aw_addr_r, `FP_REG_CTRL) && w_strb_r[0]
                       && w_data_r[`FP_CT_FLUSH];

  // Address and data taken in either order, then one write
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      aw_hold_r  <= 1'b0;
      w_hold_r   <= 1'b0;
      aw_addr_r  <= '0;
      w_data_r   <= '0;
      w_strb_r   <= '0;
      bvalid_out <= 1'b0;
      bresp_out  <= `FP_RESP_OKAY;
    end else begin
      if (awvalid_in && awready_out) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= awaddr_in;
      end
      if (wvalid_in && wready_out) begin
        w_hold_r <= 1'b1;
        w_data_r <= wdata_in;
        w_strb_r <= wstrb_in;
      end
      if (do_write) begin
        aw_hold_r  <= 1'b0;
        w_hold_r   <= 1'b0;
        bvalid_out <= 1'b1;
        bresp_out  <= (is_reg(aw_addr_r, `FP_REG_TXDATA) || is_reg(aw_addr_r, `FP_REG_CTRL))
                      ? `FP_RESP_OKAY : `FP_RESP_SLVERR;
      end else if (bready_in) begin
        bvalid_out <= 1'b0;
      end
    end
  end

  // Control word; flush bit is a command, never stored
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ctrl_r <= `FP_CTRL_RESET;
    end else if (do_write && is_reg(aw_addr_r, `FP_REG_CTRL) && w_strb_r[0]) begin
      ctrl_r <= w_data_r & 32'h0000_0006;
    end
  end

  // Pending byte; a write in the cycle it is taken still lands
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      tx_pend_r <= 1'b0;
      tx_byte_r <= '0;
    end else if (tx_wr && (!tx_pend_r || tx_take)) begin
      tx_pend_r <= 1'b1;
      tx_byte_r <= w_data_r[7:0];
    end else if (tx_take) begin
      tx_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // Strobe sequencer
  // ----------------------------------------
  host_state_type state_r;
  logic [3:0]     gap_r;
  logic [1:0]     flush_cnt_r;
  logic [7:0]     rx_byte_r;
  logic           rx_have_r;
  logic           rx_clear;

  assign tx_take = (state_r == H_WR_LOW);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      state_r <= H_IDLE;
      gap_r   <= '0;
    end else begin
      case (state_r)
        H_IDLE: begin
          if (tx_pend_r && tx_space) begin
            state_r <= H_WR_SETUP;
          end else if (ctrl_r[`FP_CT_AUTORD] && rx_avail && !rx_have_r) begin
            state_r <= H_RD_LOW;
          end
        end
        H_WR_SETUP: state_r <= H_WR_LOW;
        H_WR_LOW:   state_r <= H_WR_HOLD;
        H_WR_HOLD:  state_r <= H_GAP;
        H_RD_LOW:   state_r <= H_RD_CAP;
        H_RD_CAP:   state_r <= H_GAP;
        H_GAP: begin
          // Covers flag latency through the synchroniser
          if (gap_r == 4'(GAP_CYCLES - 1)) begin
            state_r <= H_IDLE;
            gap_r   <= '0;
          end else begin
            gap_r <= gap_r + 4'h1;
          end
        end
        default: state_r <= H_IDLE;
      endcase
    end
  end

  // Byte captured at end of read low; read of data clears, set wins
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rx_have_r <= 1'b0;
      rx_byte_r <= '0;
    end else if (state_r == H_RD_CAP) begin
      rx_have_r <= 1'b1;
      rx_byte_r <= port.bus_level;
    end else if (rx_clear) begin
      rx_have_r <= 1'b0;
    end
  end

  // Send pulse stretched over a few cycles
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      flush_cnt_r <= '0;
    end else if (flush_start) begin
      flush_cnt_r <= 2'(FLUSH_CYCLES);
    end else if (flush_cnt_r != '0) begin
      flush_cnt_r <= flush_cnt_r - 2'h1;
    end
  end

  // Bus driven only around the write strobe
  assign port.host_data_oe  = (state_r == H_WR_SETUP) || (state_r == H_WR_LOW)
                              || (state_r == H_WR_HOLD);
  assign port.host_data     = tx_byte_r;
  assign port.wr_n          = (state_r != H_WR_LOW);
  assign port.rd_n          = !((state_r == H_RD_LOW) || (state_r == H_RD_CAP));
  assign port.flush_wake_in = (flush_cnt_r != '0);
  // Held high unless software asks for a device reset
  assign port.reset_n       = !ctrl_r[`FP_CT_DEVRST];

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  logic [31:0]    status;

  always_comb begin
    status                  = '0;
    status[`FP_ST_RXAVAIL]  = rx_avail;
    status[`FP_ST_TXSPACE]  = tx_space;
    status[`FP_ST_TXPEND]   = tx_pend_r;
    status[`FP_ST_RXHAVE]   = rx_have_r;
    status[`FP_ST_SUSP]     = sync2_r[2];
    status[`FP_ST_VARIANT]  = port.variant_strap;
    status[`FP_ST_RSTGEN]   = sync2_r[3];
  end

  assign arready_out = !rvalid_out;
  assign rx_clear    = arvalid_in && arready_out && is_reg(araddr_in, `FP_REG_RXDATA);

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      rvalid_out <= 1'b0;
      rdata_out  <= '0;
      rresp_out  <= `FP_RESP_OKAY;
    end else if (arvalid_in && arready_out) begin
      rvalid_out <= 1'b1;
      rresp_out  <= `FP_RESP_OKAY;
      if (is_reg(araddr_in, `FP_REG_TXDATA)) begin
        rdata_out <= {24'h00_0000, tx_byte_r};
      end else if (is_reg(araddr_in, `FP_REG_RXDATA)) begin
        rdata_out <= {24'h00_0000, rx_byte_r};
      end else if (is_reg(araddr_in, `FP_REG_STATUS)) begin
        rdata_out <= status;
      end else if (is_reg(araddr_in, `FP_REG_CTRL)) begin
        rdata_out <= ctrl_r;
      end else begin
        rdata_out <= '0;
        rresp_out <= `FP_RESP_SLVERR;
      end
    end else if (rready_in) begin
      rvalid_out <= 1'b0;
    end
  end
endmodule : fifo_port_ctrl

// [fifo_port_monitor.sv]
`timescale 1ns/10ps
module fifo_port_monitor (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic dev_data_oe,
  input wire logic host_data_oe,
  input wire logic rx_avail_n,
  input wire logic tx_full_n,
  input wire logic variant_strap
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // ----------------------------------------
  // Link strobe and bus ownership
  // ----------------------------------------
  rd_drive_a: assert property (!rd_n |-> dev_data_oe)
    else $error("bus not driven during read");
  rd_release_a: assert property (rd_n |-> !dev_data_oe)
    else $error("bus held after read");
  wr_busy_a: assert property ($fell(wr_n) && !tx_full_n |=> tx_full_n)
    else $error("no busy after write");
  wr_allowed_a: assert property ($fell(wr_n) |-> !tx_full_n)
    else $error("write while busy");
  wr_data_a: assert property (!wr_n |-> host_data_oe && !dev_data_oe)
    else $error("write byte not on bus");
  bus_excl_a: assert property (!(dev_data_oe && host_data_oe) && (rd_n || wr_n))
    else $error("bus contention");
  rd_start_a: assert property ($fell(rd_n) |-> !rx_avail_n)
    else $error("read with no data waiting");
  variant_low_a: assert property (variant_strap == 1'b0)
    else $error("variant output high");
  // Main scenarios reached
  cover property ($fell(wr_n));
  cover property ($fell(rd_n));
  cover property ($rose(rx_avail_n));
endmodule : fifo_port_monitor

// [tb_usb_byte_fifo_parallel_port.sv]
`timescale 1ns/10ps
module tb_usb_byte_fifo_parallel_port;
  localparam int MS = 20;
  logic clk_in, resetn_in, awv, wv, bry, arv, rry, rxv, txr, cfg, susp, brs;
  logic [3:0] awa, ara;
  logic [31:0] wd, rd, rdv;
  logic [7:0] rxd, tmo;
  logic awr, wr, bv, arr, rv, rxr, txv, wake;
  logic [7:0] txd;
  logic [1:0] br, rr;
  logic [7:0] got[$], exp[$];
  int seed = 14, err_count = 0, num_checks = 0, wakes = 0;
  fifo_port_if port ();
  fifo_port_device #(.MS_CYCLES(MS), .POR_CYCLES(40)) fifo_port_device_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .port(port), .usb_rx_data_in(rxd), .usb_rx_valid_in(rxv),
    .usb_rx_ready_out(rxr), .usb_tx_data_out(txd), .usb_tx_valid_out(txv),
    .usb_tx_ready_in(txr), .usb_configured_in(cfg), .usb_suspend_in(susp),
    .usb_bus_reset_in(brs), .timeout_ms_in(tmo), .wake_req_out(wake));
  fifo_port_ctrl fifo_port_ctrl_inst (.clk_in(clk_in), .resetn_in(resetn_in), .port(port),
    .awaddr_in(awa), .awvalid_in(awv), .awready_out(awr), .wdata_in(wd), .wstrb_in(4'hF),
    .wvalid_in(wv), .wready_out(wr), .bresp_out(br), .bvalid_out(bv), .bready_in(bry),
    .araddr_in(ara), .arvalid_in(arv), .arready_out(arr), .rdata_out(rd), .rresp_out(rr),
    .rvalid_out(rv), .rready_in(rry));
  fifo_port_monitor fifo_port_monitor_inst (.clk_in(clk_in), .resetn_in(resetn_in),
    .rd_n(port.rd_n), .wr_n(port.wr_n), .dev_data_oe(port.dev_data_oe),
    .host_data_oe(port.host_data_oe), .rx_avail_n(port.rx_avail_n),
    .tx_full_n(port.tx_full_n), .variant_strap(port.variant_strap));
  initial begin
    clk_in = 0;
    forever #50 clk_in = ~clk_in;
  end
  // Host side sink stalls at random; wake pulses counted
  always @(posedge clk_in) begin
    if (txv && txr) got.push_back(txd);
    if (wake === 1'b1) wakes++;
    txr <= 1'($random(seed));
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  // AXI write, both channels offered together
  task wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    {awa, wd, awv, wv, bry} <= {a, d, 3'b111};
    do begin
      @(posedge clk_in);
      if (awr) awv <= 0;
      if (wr) wv <= 0;
    end while (bv !== 1'b1);
    bry <= 0;
  endtask : wreg
  task rreg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    {ara, arv, rry} <= {a, 2'b11};
    do begin
      @(posedge clk_in);
      if (arr) arv <= 0;
    end while (rv !== 1'b1);
    d = rd;
    rry <= 0;
  endtask : rreg
  // Poll one status bit until it reads the wanted value
  task poll(input int b, input logic v);
    logic [31:0] s;
    do rreg(4'h8, s); while (s[b] !== v);
  endtask : poll
  function automatic int tmo_cycles(input logic [7:0] ms);
    return (int'(ms) + 2) * MS;
  endfunction : tmo_cycles
  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_sim();
  end
  initial begin
    {resetn_in, awv, wv, bry, arv, rry, rxv, cfg, susp, brs, awa, ara, wd, rxd} = '0;
    tmo = 8'h02;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1;
    cfg <= 1;
    // Pass 0 drains by timeout, pass 1 by flush with a long timeout
    for (int p = 0; p < 2; p++) begin
      got.delete();
      exp.delete();
      // Long timeout in pass 1 so only the flush can release
      tmo <= p ? 8'hFF : 8'h02;
      for (int i = 0; i < 5; i++) begin
        poll(2, 1'b0);
        exp.push_back(8'($random(seed)));
        wreg(4'h0, {24'h0, exp[i]});
      end
      if (p == 1) begin
        // Last byte must be in the device before the flush
        poll(2, 1'b0);
        wreg(4'hC, 32'h0000_0001);
      end
      repeat (p ? 40 : tmo_cycles(tmo)) @(posedge clk_in);
      chk(got.size(), exp.size());
      foreach (exp[i]) chk(got[i], exp[i]);
    end
    // Receive path with auto-read
    wreg(4'hC, 32'h0000_0004);
    exp.delete();
    for (int i = 0; i < 6; i++) begin
      exp.push_back(8'($random(seed)));
      @(posedge clk_in);
      {rxd, rxv} <= {exp[i], 1'b1};
      do @(posedge clk_in); while (!rxr);
      rxv <= 0;
    end
    chk(port.rx_avail_n, 1'b0);
    foreach (exp[i]) begin
      poll(3, 1'b1);
      rreg(4'h4, rdv);
      chk(rdv, {24'h0, exp[i]});
    end
    repeat (10) @(posedge clk_in);
    chk(port.rx_avail_n, 1'b1);
    chk(port.suspend_ind, 1'b0);
    susp <= 1;
    wreg(4'hC, 32'h0000_0001);
    repeat (10) @(posedge clk_in);
    chk(port.suspend_ind, 1'b1);
    chk(wakes, 1);
    chk(port.reset_gen_level, 1'b1);
    wreg(4'hC, 32'h0000_0002);
    repeat (5) @(posedge clk_in);
    chk(port.reset_gen_level, 1'b0);
    wreg(4'hC, 32'h0000_0000);
    repeat (30) @(posedge clk_in);
    chk(port.reset_gen_level, 1'b0);
    repeat (30) @(posedge clk_in);
    chk(port.reset_gen_level, 1'b1);
    brs <= 1;
    repeat (5) @(posedge clk_in);
    chk(port.reset_gen_level, 1'b1);
    brs <= 0;
    end_sim();
  end
endmodule : tb_usb_byte_fifo_parallel_port
